// ---- tb/alert_mask_and_vout_format_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_params.svh"
module alert_mask_and_vout_format_regs_tb;
	// clock, reset, enable (enable dropped only in the stall test)
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	// host user port
	logic op_start = 1'b0;
	logic op_write = 1'b0;
	alert_mask_pkg::mask_group_e op_target = alert_mask_pkg::grp_none;
	logic op_page = 1'b0;
	logic [7:0] op_data = 8'h00;
	logic op_busy, op_done, op_error;
	logic [7:0] op_rdata;
	// device inputs and outputs
	logic [1:0][7:0] nvm_oc, nvm_th, nvm_vf, st_oc, st_th, st_vf;
	logic [7:0] nvm_ip, nvm_cl, st_ip, st_cl;
	logic alert_o, alert_oe;
	alert_mask_pkg::vout_enc_e enc [2];
	logic [1:0][4:0] vparam;
	// reference images, index by target code then page
	logic [7:0] mdl [7][2];
	int fails = 0;
	int checks = 0;
	int seed = 32'h0c58_793e;
	int g, p, i;
	logic [7:0] v;
	always #50 clk = ~clk;
	pmbus_link_if pmbus_link_if_i ();
	alert_mask_device alert_mask_device_i (.clk(clk), .rst(rst), .ce(ce), .link(pmbus_link_if_i),
		.nvm_output_current(nvm_oc), .nvm_input_power(nvm_ip), .nvm_thermal(nvm_th),
		.nvm_comm_logic(nvm_cl), .nvm_vendor_faults(nvm_vf), .status_output_current(st_oc),
		.status_input_power(st_ip), .status_thermal(st_th), .status_comm_logic(st_cl),
		.status_vendor_faults(st_vf), .smbalert_o(alert_o), .smbalert_oe(alert_oe),
		.vout_encoding(enc), .vout_param(vparam));
	alert_mask_host alert_mask_host_i (.clk(clk), .rst(rst), .ce(ce), .op_start(op_start),
		.op_write(op_write), .op_target(op_target), .op_page(op_page), .op_data(op_data),
		.op_busy(op_busy), .op_done(op_done), .op_rdata(op_rdata), .op_error(op_error),
		.link(pmbus_link_if_i));
	alert_mask_monitor alert_mask_monitor_i (.clk(clk), .rst(rst), .req_valid(pmbus_link_if_i.req_valid),
		.req_write(pmbus_link_if_i.req_write), .req_page(pmbus_link_if_i.req_page),
		.req_cmd(pmbus_link_if_i.req_cmd), .req_sel(pmbus_link_if_i.req_sel),
		.req_data(pmbus_link_if_i.req_data), .rsp_valid(pmbus_link_if_i.rsp_valid),
		.rsp_data(pmbus_link_if_i.rsp_data), .rsp_error(pmbus_link_if_i.rsp_error));
	// byte compare
	task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_byte
	// single bit compare
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp_bit
	task automatic give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict
	// writable bits per target; format byte is fully writable
	function automatic logic [7:0] wm(input int tg);
		case (tg)
			1: return 8'hB8;
			3: return 8'hC0;
			4: return 8'hF3;
			5: return 8'hF9;
			default: return 8'hFF;
		endcase
	endfunction : wm
	// one user operation from a falling edge; done wait is bounded
	task automatic run_op(input logic wr, input int tg, input logic pg, input logic [7:0] d);
		int n;
		op_start = 1'b1;
		op_write = wr;
		op_target = alert_mask_pkg::mask_group_e'(tg);
		op_page = pg;
		op_data = d;
		@(negedge clk);
		op_start = 1'b0;
		cmp_bit("op busy", 1'b1, op_busy);
		for (n = 0; n < 8 && op_done !== 1'b1; n++) begin
			@(negedge clk);
		end
		if (op_done !== 1'b1) begin
			fails++;
			$display("[ERR] op_done expected 1 seen %b", op_done);
			give_verdict();
		end
		// take, request, answer, done: two more falling edges after the first
		cmp_byte("done latency", 8'h02, 8'(n));
	endtask : run_op
	// access plus model update or read compare; shared groups keep one copy
	task automatic xfer(input logic wr, input int tg, input logic pg, input logic [7:0] d);
		int pi;
		pi = (tg == 2 || tg == 4) ? 0 : int'(pg);
		run_op(wr, tg, pg, d);
		if (wr) begin
			mdl[tg][pi] = d & wm(tg);
		end else begin
			cmp_byte("read data", mdl[tg][pi], op_rdata);
		end
		cmp_bit("op error", 1'b0, op_error);
	endtask : xfer
	// alert expected from status against the unmasked writable bits
	function automatic logic alert_exp();
		logic r;
		r = |(st_ip & ~mdl[2][0]) | |(st_cl & ~mdl[4][0] & 8'hF3);
		for (int q = 0; q < 2; q++) begin
			r |= |(st_oc[q] & ~mdl[1][q] & 8'hB8) | |(st_th[q] & ~mdl[3][q] & 8'hC0) | |(st_vf[q] & ~mdl[5][q] & 8'hF9);
		end
		return r;
	endfunction : alert_exp
	task automatic read_all;
		for (g = 1; g < 7; g++) for (p = 0; p < 2; p++) xfer(1'b0, g, p[0], 8'h00);
	endtask : read_all
	initial begin
		nvm_oc = 16'($random(seed));
		nvm_th = 16'($random(seed));
		nvm_vf = 16'($random(seed));
		nvm_ip = 8'($random(seed));
		nvm_cl = 8'($random(seed));
		{st_oc, st_th, st_vf, st_ip, st_cl} = '0;
		for (p = 0; p < 2; p++) begin
			mdl[1][p] = nvm_oc[p] & 8'hB8;
			mdl[3][p] = nvm_th[p] & 8'hC0;
			mdl[5][p] = nvm_vf[p] & 8'hF9;
			mdl[6][p] = 8'h16;
		end
		mdl[2][0] = nvm_ip;
		mdl[4][0] = nvm_cl & 8'hF3;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		read_all();
		$display("test reset values done");
		for (i = 0; i < 3; i++) for (g = 1; g < 6; g++) for (p = 0; p < 2; p++) xfer(1'b1, g, p[0], 8'($random(seed)));
		read_all();
		$display("test mask writes done");
		// every mode code, alternate pages
		for (i = 0; i < 8; i++) begin
			v = {i[2:0], 5'($random(seed))};
			xfer(1'b1, 6, i[0], v);
			cmp_byte("mode", {5'h00, v[7:5]}, {5'h00, enc[i[0]]});
			cmp_byte("param", {3'h0, v[4:0]}, {3'h0, vparam[i[0]]});
		end
		read_all();
		$display("test format byte done");
		run_op(1'b0, 0, 1'b0, 8'h00);
		cmp_bit("bad target error", 1'b1, op_error);
		cmp_byte("bad target data", 8'h00, op_rdata);
		$display("test bad target done");
		// stall: with the enable low neither end may move
		xfer(1'b1, 2, 1'b0, 8'h00);
		ce = 1'b0;
		st_ip = 8'hFF;
		op_start = 1'b1;
		op_write = 1'b1;
		op_target = alert_mask_pkg::grp_input_power;
		op_data = 8'hA5;
		repeat (4) @(negedge clk);
		cmp_bit("stalled busy", 1'b0, op_busy);
		cmp_bit("stalled alert", 1'b0, alert_oe);
		ce = 1'b1;
		xfer(1'b0, 2, 1'b0, 8'h00);
		cmp_bit("resumed alert", alert_exp(), alert_oe);
		$display("test clock enable stall done");
		for (i = 0; i < 60; i++) begin
			if (i % 3 == 0) begin
				xfer(1'b1, 1 + (i / 3) % 5, i[2], 8'($random(seed)) & 8'($random(seed)));
			end
			if (i[0]) begin
				// only masked or reserved bits set: the pin has to stay released
				st_oc = {mdl[1][1], mdl[1][0]} | 16'h4747;
				st_th = {mdl[3][1], mdl[3][0]} | 16'h3F3F;
				st_vf = {mdl[5][1], mdl[5][0]} | 16'h0606;
				st_ip = mdl[2][0];
				st_cl = mdl[4][0] | 8'h0C;
			end else begin
				// sparse random conditions, mostly unmasked somewhere
				{st_oc, st_th, st_vf} = 48'({$random(seed), $random(seed)}) & 48'({$random(seed), $random(seed)});
				st_ip = 8'($random(seed)) & 8'($random(seed));
				st_cl = 8'($random(seed)) & 8'($random(seed));
			end
			@(negedge clk);
			cmp_bit("alert enable", alert_exp(), alert_oe);
			cmp_bit("alert drive", 1'b0, alert_o);
		end
		$display("test alert gating done");
		give_verdict();
	end
endmodule : alert_mask_and_vout_format_regs_tb
`default_nettype wire

// ---- tb/alert_mask_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "alert_mask_params.svh"
// watches the link between the two ends
module alert_mask_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_page,
	input wire logic [7:0] req_cmd,
	input wire logic [7:0] req_sel,
	input wire logic [7:0] req_data,
	// link answer
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_error
);
	// mask access and known selector
	logic mask_req;
	logic sel_ok;
	assign mask_req = req_valid && req_cmd == `CMD_ALERT_MASK;
	assign sel_ok = req_sel inside {`SEL_OUTPUT_CURRENT, `SEL_INPUT_POWER, `SEL_THERMAL, `SEL_COMM_LOGIC,
		`SEL_VENDOR_FAULTS};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_answer_follows:
	assert property (req_valid |=> rsp_valid && !req_valid) else $error("answer missing after request");
	chk_no_stray_answer:
	assert property (rsp_valid |-> $past(req_valid)) else $error("answer without request");
	chk_host_spacing:
	assert property (req_valid |=> !req_valid [*2]) else $error("requests too close");
	chk_write_ack_zero:
	assert property (rsp_valid && req_write |-> rsp_data == 8'h00) else $error("write answer carries data");
	chk_bad_sel_error:
	assert property (mask_req && !sel_ok |=> rsp_error && rsp_data == 8'h00) else $error("unknown selector taken");
	chk_good_sel_ok:
	assert property (mask_req && sel_ok |=> !rsp_error) else $error("known selector refused");
	chk_thermal_low_zero:
	assert property (mask_req && !req_write && req_sel == `SEL_THERMAL |=> rsp_data[5:0] == 6'h00)
		else $error("thermal low bits not zero");
	chk_comm_reserved_zero:
	assert property (mask_req && !req_write && req_sel == `SEL_COMM_LOGIC |=> rsp_data[3:2] == 2'b00)
		else $error("comm reserved bits not zero");
	chk_vendor_reserved_zero:
	assert property (mask_req && !req_write && req_sel == `SEL_VENDOR_FAULTS |=> rsp_data[2:1] == 2'b00)
		else $error("vendor reserved bits not zero");
endmodule : alert_mask_monitor
`default_nettype wire

// ---- verilog/alert_mask_device.sv ----
// Contract
// - cleared mask bit lets condition raise alert
// - set mask bit blocks condition from alert
// - selector 7Ch writes input-power mask
// - selector 7Dh writes thermal mask
// - selector 7Eh writes comm/logic mask
// - selector 80h writes vendor-fault mask
// - all masks share command 1Bh, selector picks
// - thermal mask keeps only bits 7,6
// - format byte: 3-bit mode, 5-bit parameter
// - mode field selects voltage data encoding
// - parameter field qualifies the selected mode
// - format resets to ulinear16, exponent -10
// - format byte writable, host writes it with command 20h
`timescale 1ns/1ps
`default_nettype none

`include "alert_mask_params.svh"

module alert_mask_device (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// link to the host controller
	pmbus_link_if.device link,
	// power-up mask values from non-volatile storage
	input wire logic [`PAGE_COUNT-1:0][7:0] nvm_output_current,
	input wire logic [7:0] nvm_input_power,
	input wire logic [`PAGE_COUNT-1:0][7:0] nvm_thermal,
	input wire logic [7:0] nvm_comm_logic,
	input wire logic [`PAGE_COUNT-1:0][7:0] nvm_vendor_faults,
	// live status conditions
	input wire logic [`PAGE_COUNT-1:0][7:0] status_output_current,
	input wire logic [7:0] status_input_power,
	input wire logic [`PAGE_COUNT-1:0][7:0] status_thermal,
	input wire logic [7:0] status_comm_logic,
	input wire logic [`PAGE_COUNT-1:0][7:0] status_vendor_faults,
	// open-drain alert pin
	output logic smbalert_o,
	output logic smbalert_oe,
	// decoded output voltage format per page
	output alert_mask_pkg::vout_enc_e vout_encoding [`PAGE_COUNT],
	output logic [`PAGE_COUNT-1:0][4:0] vout_param
);

	// mask storage, paged groups one byte per page
	logic [`PAGE_COUNT-1:0][7:0] alert_mask_output_current;
	logic [7:0] alert_mask_input_power;
	logic [`PAGE_COUNT-1:0][7:0] alert_mask_thermal;
	logic [7:0] alert_mask_comm_logic;
	logic [`PAGE_COUNT-1:0][7:0] alert_mask_vendor_faults;
	// output voltage format byte per page
	logic [`PAGE_COUNT-1:0][7:0] output_voltage_format;

	// request decode
	alert_mask_pkg::mask_group_e req_group; // selected mask group
	logic mask_cmd; // command addresses the mask bank
	logic fmt_cmd; // command addresses the format byte
	logic wr_mask; // accepted mask write this cycle
	logic wr_fmt; // accepted format write this cycle

	// read mux and per-group alert hits
	logic [7:0] next_rsp_data;
	logic next_rsp_error;
	logic [`PAGE_COUNT-1:0] hit_output_current;
	logic [`PAGE_COUNT-1:0] hit_thermal;
	logic [`PAGE_COUNT-1:0] hit_vendor_faults;
	logic hit_input_power;
	logic hit_comm_logic;
	logic next_alert;

	// shared command, group picked by selector
	assign req_group = alert_mask_pkg::sel_to_group(link.req_sel);
	assign mask_cmd = (link.req_cmd == `CMD_ALERT_MASK);
	assign fmt_cmd = (link.req_cmd == `CMD_VOUT_FORMAT);
	// requests only count while the clock enable is high
	assign wr_mask = ce && link.req_valid && link.req_write && mask_cmd;
	assign wr_fmt = ce && link.req_valid && link.req_write && fmt_cmd;

	// output-current mask, one per page
	always_ff @(posedge clk) begin
		if (rst) begin
			alert_mask_output_current <= nvm_output_current & {`PAGE_COUNT{`WMASK_OUTPUT_CURRENT}};
		end else if (wr_mask && req_group == alert_mask_pkg::grp_output_current) begin
			alert_mask_output_current[link.req_page] <= link.req_data & `WMASK_OUTPUT_CURRENT;
		end
	end

	// input-power mask, shared by both pages
	always_ff @(posedge clk) begin
		if (rst) begin
			alert_mask_input_power <= nvm_input_power & `WMASK_INPUT_POWER;
		end else if (wr_mask && req_group == alert_mask_pkg::grp_input_power) begin
			alert_mask_input_power <= link.req_data & `WMASK_INPUT_POWER;
		end
	end

	// thermal mask, one per page
	always_ff @(posedge clk) begin
		if (rst) begin
			// bits 5:0 held at zero from reset on
			alert_mask_thermal <= nvm_thermal & {`PAGE_COUNT{`WMASK_THERMAL}};
		end else if (wr_mask && req_group == alert_mask_pkg::grp_thermal) begin
			// selector 7Dh, only fault and warning bits kept
			alert_mask_thermal[link.req_page] <= link.req_data & `WMASK_THERMAL;
		end
	end

	// comm/logic mask, shared by both pages
	always_ff @(posedge clk) begin
		if (rst) begin
			alert_mask_comm_logic <= nvm_comm_logic & `WMASK_COMM_LOGIC;
		end else if (wr_mask && req_group == alert_mask_pkg::grp_comm_logic) begin
			alert_mask_comm_logic <= link.req_data & `WMASK_COMM_LOGIC;
		end
	end

	// vendor-fault mask, one per page
	always_ff @(posedge clk) begin
		if (rst) begin
			alert_mask_vendor_faults <= nvm_vendor_faults & {`PAGE_COUNT{`WMASK_VENDOR_FAULTS}};
		end else if (wr_mask && req_group == alert_mask_pkg::grp_vendor_faults) begin
			alert_mask_vendor_faults[link.req_page] <= link.req_data & `WMASK_VENDOR_FAULTS;
		end
	end

	// output voltage format byte, one per page
	always_ff @(posedge clk) begin
		if (rst) begin
			// ulinear16, exponent -10 on every page
			output_voltage_format <= {`PAGE_COUNT{`VFMT_RESET}};
		end else if (wr_fmt) begin
			output_voltage_format[link.req_page] <= link.req_data;
		end
	end

	// format fields straight from the register
	always_comb begin
		for (int p = 0; p < `PAGE_COUNT; p++) begin
			vout_encoding[p] = alert_mask_pkg::vout_enc_e'(output_voltage_format[p][`VFMT_MODE_MSB:`VFMT_MODE_LSB]);
			vout_param[p] = output_voltage_format[p][`VFMT_PARAM_MSB:`VFMT_PARAM_LSB];
		end
	end

	// read mux, unknown command or selector answers zero with error
	always_comb begin
		next_rsp_data = 8'h00;
		next_rsp_error = 1'b0;
		if (mask_cmd) begin
			// stored bytes already hold zero in reserved positions
			case (req_group)
				alert_mask_pkg::grp_output_current: next_rsp_data = alert_mask_output_current[link.req_page];
				alert_mask_pkg::grp_input_power: next_rsp_data = alert_mask_input_power;
				alert_mask_pkg::grp_thermal: next_rsp_data = alert_mask_thermal[link.req_page];
				alert_mask_pkg::grp_comm_logic: next_rsp_data = alert_mask_comm_logic;
				alert_mask_pkg::grp_vendor_faults: next_rsp_data = alert_mask_vendor_faults[link.req_page];
				default: next_rsp_error = 1'b1;
			endcase
		end else if (fmt_cmd) begin
			next_rsp_data = output_voltage_format[link.req_page];
		end else begin
			next_rsp_error = 1'b1;
		end
	end

	// answer one cycle after every request, reads and writes alike
	always_ff @(posedge clk) begin
		if (rst) begin
			link.rsp_valid <= 1'b0;
			link.rsp_data <= 8'h00;
			link.rsp_error <= 1'b0;
		end else if (ce) begin
			link.rsp_valid <= link.req_valid;
			// write answers carry no data, only the error flag
			link.rsp_data <= (link.req_valid && !link.req_write) ? next_rsp_data : 8'h00;
			link.rsp_error <= link.req_valid && next_rsp_error;
		end
	end

	// per-page gates for the paged groups
	genvar gp;
	generate
		for (gp = 0; gp < `PAGE_COUNT; gp++) begin : g_page
			alert_mask_gate #(.SUPPORTED(`WMASK_OUTPUT_CURRENT)) u_cur (
				.status(status_output_current[gp]),
				.mask(alert_mask_output_current[gp]),
				.hit(hit_output_current[gp])
			);
			alert_mask_gate #(.SUPPORTED(`WMASK_THERMAL)) u_thr (
				.status(status_thermal[gp]),
				.mask(alert_mask_thermal[gp]),
				.hit(hit_thermal[gp])
			);
			alert_mask_gate #(.SUPPORTED(`WMASK_VENDOR_FAULTS)) u_ven (
				.status(status_vendor_faults[gp]),
				.mask(alert_mask_vendor_faults[gp]),
				.hit(hit_vendor_faults[gp])
			);
		end
	endgenerate

	// shared groups gate once
	alert_mask_gate #(.SUPPORTED(`WMASK_INPUT_POWER)) u_inp (
		.status(status_input_power),
		.mask(alert_mask_input_power),
		.hit(hit_input_power)
	);
	alert_mask_gate #(.SUPPORTED(`WMASK_COMM_LOGIC)) u_cml (
		.status(status_comm_logic),
		.mask(alert_mask_comm_logic),
		.hit(hit_comm_logic)
	);

	// any unmasked set condition in a writable bit position raises the alert
	assign next_alert = (|hit_output_current) | (|hit_thermal) | (|hit_vendor_faults)
		| hit_input_power | hit_comm_logic;

	// alert pin: registered enable, pulls low only
	always_ff @(posedge clk) begin
		if (rst) begin
			smbalert_oe <= 1'b0;
			smbalert_o <= 1'b0;
		end else if (ce) begin
			// masked conditions never reach the pin
			smbalert_oe <= next_alert;
			smbalert_o <= 1'b0;
		end
	end

endmodule : alert_mask_device

`default_nettype wire

// ---- verilog/alert_mask_gate.sv ----
`timescale 1ns/1ps
`default_nettype none

// one status group against its mask: high when any supported, unmasked bit is set
module alert_mask_gate #(
	parameter logic [7:0] SUPPORTED = 8'hFF
) (
	// status and mask
	input wire logic [7:0] status,
	input wire logic [7:0] mask,
	// result
	output logic hit
);
	// a cleared mask bit lets its status through, a set one blocks it
	assign hit = |(status & ~mask & SUPPORTED);
endmodule : alert_mask_gate

`default_nettype wire

// ---- verilog/alert_mask_host.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "alert_mask_params.svh"

module alert_mask_host (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// user command port
	input wire logic op_start,
	input wire logic op_write,
	input wire alert_mask_pkg::mask_group_e op_target,
	input wire logic op_page,
	input wire logic [7:0] op_data,
	output logic op_busy,
	output logic op_done,
	output logic [7:0] op_rdata,
	output logic op_error,
	// link to the device
	pmbus_link_if.host link
);

	alert_mask_pkg::host_state_e state; // sequencer state
	logic take; // start accepted this cycle

	// a start is only taken while idle; during busy it is dropped
	assign take = ce && op_start && (state == alert_mask_pkg::hs_idle);
	assign op_busy = (state != alert_mask_pkg::hs_idle);

	// sequencer: one request in flight at a time
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= alert_mask_pkg::hs_idle;
		end else if (ce) begin
			case (state)
				alert_mask_pkg::hs_idle: begin
					if (take) begin
						state <= alert_mask_pkg::hs_wait;
					end
				end
				alert_mask_pkg::hs_wait: begin
					if (link.rsp_valid) begin
						state <= alert_mask_pkg::hs_idle;
					end
				end
				default: state <= alert_mask_pkg::hs_idle;
			endcase
		end
	end

	// request fields, strobe held for one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			link.req_valid <= 1'b0;
			link.req_write <= 1'b0;
			link.req_page <= 1'b0;
			link.req_cmd <= 8'h00;
			link.req_sel <= 8'h00;
			link.req_data <= 8'h00;
		end else if (ce) begin
			link.req_valid <= take;
			if (take) begin
				link.req_write <= op_write;
				link.req_page <= op_page;
				// every mask target goes through 1Bh
				// format byte reached by its own command
				link.req_cmd <= (op_target == alert_mask_pkg::grp_vout_format) ? `CMD_VOUT_FORMAT : `CMD_ALERT_MASK;
				// selector in the low byte, 7Ch etc.
				link.req_sel <= alert_mask_pkg::group_to_sel(op_target);
				// mask or format value in the high byte
				link.req_data <= op_write ? op_data : 8'h00;
			end
		end
	end

	// answer capture, done pulses for one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			op_done <= 1'b0;
			op_rdata <= 8'h00;
			op_error <= 1'b0;
		end else if (ce) begin
			op_done <= (state == alert_mask_pkg::hs_wait) && link.rsp_valid;
			if ((state == alert_mask_pkg::hs_wait) && link.rsp_valid) begin
				op_rdata <= link.rsp_data;
				op_error <= link.rsp_error;
			end
		end
	end

endmodule : alert_mask_host

`default_nettype wire

// ---- verilog/alert_mask_params.svh ----
`ifndef ALERT_MASK_PARAMS_SVH
`define ALERT_MASK_PARAMS_SVH

// command codes on the link
`define CMD_ALERT_MASK 8'h1B
`define CMD_VOUT_FORMAT 8'h20

// status group selectors carried in the low data byte
`define SEL_OUTPUT_CURRENT 8'h7B
`define SEL_INPUT_POWER 8'h7C
`define SEL_THERMAL 8'h7D
`define SEL_COMM_LOGIC 8'h7E
`define SEL_VENDOR_FAULTS 8'h80

// writable bit positions of each mask, all others read as zero
`define WMASK_OUTPUT_CURRENT 8'hB8
`define WMASK_INPUT_POWER 8'hFF
`define WMASK_THERMAL 8'hC0
`define WMASK_COMM_LOGIC 8'hF3
`define WMASK_VENDOR_FAULTS 8'hF9

// named mask bits
`define BIT_THERMAL_FAULT 7
`define BIT_THERMAL_WARNING 6
`define BIT_POWERUP_EVENT 7
`define BIT_SUPPLY_FAULT 0
`define BIT_INPUT_OVERPOWER 0

// output voltage format byte layout and reset value
`define VFMT_MODE_MSB 7
`define VFMT_MODE_LSB 5
`define VFMT_PARAM_MSB 4
`define VFMT_PARAM_LSB 0
`define VFMT_RESET 8'h16

// number of output pages
`define PAGE_COUNT 2

`endif

// ---- verilog/alert_mask_pkg.sv ----
`include "alert_mask_params.svh"

package alert_mask_pkg;

	// register targets reachable over the link
	typedef enum logic [2:0] {
		grp_none = 3'b000,
		grp_output_current = 3'b001,
		grp_input_power = 3'b010,
		grp_thermal = 3'b011,
		grp_comm_logic = 3'b100,
		grp_vendor_faults = 3'b101,
		grp_vout_format = 3'b110
	} mask_group_e;

	// encodings selected by the mode field of the format byte
	typedef enum logic [2:0] {
		enc_ulinear16 = 3'b000,
		enc_vid = 3'b001,
		enc_direct = 3'b010,
		enc_half_float = 3'b011,
		enc_res4 = 3'b100,
		enc_res5 = 3'b101,
		enc_res6 = 3'b110,
		enc_res7 = 3'b111
	} vout_enc_e;

	// host sequencer states
	typedef enum logic [1:0] {
		hs_idle = 2'b00,
		hs_wait = 2'b01
	} host_state_e;

	// selector byte to mask group, grp_none when unknown
	function automatic mask_group_e sel_to_group(input logic [7:0] sel);
		case (sel)
			`SEL_OUTPUT_CURRENT: sel_to_group = grp_output_current;
			`SEL_INPUT_POWER: sel_to_group = grp_input_power;
			`SEL_THERMAL: sel_to_group = grp_thermal;
			`SEL_COMM_LOGIC: sel_to_group = grp_comm_logic;
			`SEL_VENDOR_FAULTS: sel_to_group = grp_vendor_faults;
			default: sel_to_group = grp_none;
		endcase
	endfunction : sel_to_group

	// mask group to selector byte, zero for non-mask targets
	function automatic logic [7:0] group_to_sel(input mask_group_e grp);
		case (grp)
			grp_output_current: group_to_sel = `SEL_OUTPUT_CURRENT;
			grp_input_power: group_to_sel = `SEL_INPUT_POWER;
			grp_thermal: group_to_sel = `SEL_THERMAL;
			grp_comm_logic: group_to_sel = `SEL_COMM_LOGIC;
			grp_vendor_faults: group_to_sel = `SEL_VENDOR_FAULTS;
			default: group_to_sel = 8'h00;
		endcase
	endfunction : group_to_sel

endpackage : alert_mask_pkg

// ---- verilog/pmbus_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// transaction-level link between host controller and device
interface pmbus_link_if;
	logic req_valid; // one-cycle request strobe
	logic req_write; // 1 write, 0 read
	logic req_page; // output page for paged targets
	logic [7:0] req_cmd; // command code
	logic [7:0] req_sel; // low data byte: status group selector
	logic [7:0] req_data; // high data byte: mask or format value
	logic rsp_valid; // one-cycle answer strobe
	logic [7:0] rsp_data; // read data
	logic rsp_error; // unsupported command or selector

	modport device (
		input req_valid, req_write, req_page, req_cmd, req_sel, req_data,
		output rsp_valid, rsp_data, rsp_error
	);

	modport host (
		output req_valid, req_write, req_page, req_cmd, req_sel, req_data,
		input rsp_valid, rsp_data, rsp_error
	);
endinterface : pmbus_link_if

`default_nettype wire
